// ===== src/ctr_pkg.sv
// constants for the charger timer / thermistor control and summary status slice
// assumes a byte-wide register access port driven by the serial bus front end
package ctr_pkg;
  localparam logic [7:0] CTR_OFS_TIMER_CTL = 8'h16;
  localparam logic [7:0] CTR_OFS_THERM_CTL = 8'h17;
  localparam logic [7:0] CTR_OFS_STATUS = 8'h18;
  // timer control fields
  localparam int CTR_BIAS_BIT = 7;
  localparam int CTR_DOUBLE_BIT = 6;
  localparam int CTR_FAST_LSB = 4;
  localparam int CTR_PREQ_LSB = 2;
  localparam int CTR_TOPOFF_LSB = 0;
  localparam logic [7:0] CTR_TIMER_CTL_RST = 8'h95;
  // thermal control fields
  localparam int CTR_BETA_LSB = 5;
  localparam int CTR_THREG_LSB = 0;
  localparam logic [7:0] CTR_THERM_CTL_RST = 8'h24;
  // reserved bits 4:3 are masked off on write and always read back zero
  localparam logic [7:0] CTR_THERM_CTL_WMASK = 8'hE7;
  // status fields
  localparam int CTR_ATTACH_BIT = 7;
  localparam int CTR_BATOK_BIT = 6;
  localparam int CTR_INPWR_BIT = 5;
  localparam int CTR_CHGOK_BIT = 4;
  localparam logic [7:0] CTR_STATUS_RST = 8'h10;
  localparam logic [2:0] CTR_BAT_MISSING = 3'h0;
  localparam logic [2:0] CTR_BAT_IN_RESET = 3'h7;
  localparam logic [1:0] CTR_PWR_VALID = 2'h3;
  localparam logic [2:0] CTR_TS_SUSPEND_A = 3'h1;
  localparam logic [2:0] CTR_TS_SUSPEND_B = 3'h4;
  // timer durations in seconds, times ten for the top-off tenths
  localparam logic [15:0] CTR_FAST_SEC_BASE = 16'h2A30;
  localparam logic [15:0] CTR_FAST_SEC_STEP = 16'h1C20;
  localparam logic [15:0] CTR_PREQ_SEC_STEP = 16'h0384;
  localparam logic [15:0] CTR_TOPOFF_DSEC_STEP = 16'h0F00;
endpackage

// ===== src/ctr_sync2.sv
// two-stage synchroniser for a bus of status pins
// assumes inputs are quasi-static levels from analog/other logic
`timescale 1ns/1ps
module ctr_sync2 #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s1_next;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    s1_next = d;
    q_next = s1_reg;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s1_reg <= '0;
      q_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      q_reg <= q_next;
    end
  end

  assign q = q_reg;
endmodule

// ===== src/ctr_durations.sv
// decodes programmed timer codes into effective durations
// assumes codes come from the control register on the same clock
`timescale 1ns/1ps
module ctr_durations (
  input wire logic [1:0] fast_charge_duration,
  input wire logic [1:0] prequal_duration,
  input wire logic [1:0] topoff_duration,
  input wire logic safety_timer_double,
  output logic [15:0] fast_sec,
  output logic [15:0] prequal_sec,
  output logic [15:0] topoff_dsec
);
  import ctr_pkg::*;

  function automatic logic [15:0] scale(input logic [15:0] step, input logic [1:0] code);
    scale = 16'(step * 16'(code));
  endfunction

  logic [15:0] fast_base;
  logic [15:0] preq_base;

  always_comb begin
    fast_base = 16'(CTR_FAST_SEC_BASE + scale(CTR_FAST_SEC_STEP, fast_charge_duration));
    preq_base = scale(CTR_PREQ_SEC_STEP, 2'(prequal_duration + 2'h1));
    if (prequal_duration == 2'h3) begin
      preq_base = 16'(CTR_PREQ_SEC_STEP * 16'h0004);
    end
    topoff_dsec = scale(CTR_TOPOFF_DSEC_STEP / 16'h0010, topoff_duration) * 16'h0010;
    fast_sec = safety_timer_double ? 16'(fast_base << 1) : fast_base;
    prequal_sec = safety_timer_double ? 16'(preq_base << 1) : preq_base;
  end
endmodule

// ===== src/ctr_regs.sv
// charger timer / thermistor control and summary status registers
// assumes a byte register port from the serial bus target, one clock, sync reset
// Function
// - register 0x16 is read-write, writes blocked by the charger lock.
// - bit 7 of 0x16 selects thermistor bias; resets to 1.
// - fast-charge code 00..11 means 3, 5, 7, 9 hours; resets to 01.
// - pre-qualification code 00..11 means 15..60 minutes; resets to 01.
// - top-off code 00..11 means 0, 6.4, 12.8, 19.2 minutes; resets 01.
// - doubling bit doubles pre-qualification and fast-charge durations.
// - bits 7:5 of 0x17 select thermistor beta; resets to 001.
// - low three bits of 0x17 set regulation 80..115 C; resets 100.
// - status register 0x18 is read-only; writes change nothing.
// - status bit 7 shows battery attach detected; resets to 0.
// - status bit 6 is 0 for battery detail 000 or 111, else 1.
// - status bit 5 is 1 only when input power detail equals 11.
// - status bit 4 is 0 for thermistor 001/100 or timer nonzero; resets 1.
// - battery detail 111 means charger in reset, also its reset value.
// - input power detail 11 means input voltage fully valid.
`timescale 1ns/1ps
module ctr_regs (
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic charger_write_lock,
  input wire logic battery_attach_detected,
  input wire logic [2:0] battery_detail_field,
  input wire logic [1:0] input_power_detail_field,
  input wire logic [2:0] thermistor_detail_field,
  input wire logic [1:0] safety_timer_state,
  input wire logic input_current_limit_condition,
  output logic thermistor_bias_select,
  output logic safety_timer_double,
  output logic [1:0] fast_charge_duration,
  output logic [1:0] prequal_duration,
  output logic [1:0] topoff_duration,
  output logic [2:0] thermistor_beta_choice,
  output logic [2:0] thermal_regulation_threshold,
  output logic [15:0] fast_charge_seconds,
  output logic [15:0] prequal_seconds,
  output logic [15:0] topoff_deciseconds,
  output logic status_unreliable
);
  import ctr_pkg::*;

  // pin group: attach, battery detail, power detail, thermistor, timer, limit
  localparam int PW = 12;
  logic [PW-1:0] pins_raw;
  logic [PW-1:0] pins_sync;
  logic attach_s;
  logic [2:0] bat_s;
  logic [1:0] pwr_s;
  logic [2:0] ts_s;
  logic [1:0] tmr_s;
  logic ilim_s;

  assign pins_raw = {input_current_limit_condition, safety_timer_state,
                     thermistor_detail_field, input_power_detail_field,
                     battery_detail_field, battery_attach_detected};

  ctr_sync2 #(.W(PW)) u_sync (
    .clk(clk),
    .reset(reset),
    .d(pins_raw),
    .q(pins_sync)
  );

  assign attach_s = pins_sync[0];
  assign bat_s = pins_sync[3:1];
  assign pwr_s = pins_sync[5:4];
  assign ts_s = pins_sync[8:6];
  assign tmr_s = pins_sync[10:9];
  assign ilim_s = pins_sync[11];

  logic [7:0] timer_ctl_reg;
  logic [7:0] timer_ctl_next;
  logic [7:0] therm_ctl_reg;
  logic [7:0] therm_ctl_next;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic unrel_reg;
  logic unrel_next;
  logic [15:0] fast_sec_reg;
  logic [15:0] fast_sec_next;
  logic [15:0] preq_sec_reg;
  logic [15:0] preq_sec_next;
  logic [15:0] topoff_reg;
  logic [15:0] topoff_next;
  logic [15:0] fast_sec_c;
  logic [15:0] preq_sec_c;
  logic [15:0] topoff_c;

  function automatic logic battery_valid(input logic [2:0] code);
    battery_valid = (code != CTR_BAT_MISSING) && (code != CTR_BAT_IN_RESET);
  endfunction

  ctr_durations u_dur (
    .fast_charge_duration(timer_ctl_reg[CTR_FAST_LSB +: 2]),
    .prequal_duration(timer_ctl_reg[CTR_PREQ_LSB +: 2]),
    .topoff_duration(timer_ctl_reg[CTR_TOPOFF_LSB +: 2]),
    .safety_timer_double(timer_ctl_reg[CTR_DOUBLE_BIT]),
    .fast_sec(fast_sec_c),
    .prequal_sec(preq_sec_c),
    .topoff_dsec(topoff_c)
  );

  // control register writes
  always_comb begin
    timer_ctl_next = timer_ctl_reg;
    therm_ctl_next = therm_ctl_reg;
    if (reg_wr && reg_addr == CTR_OFS_TIMER_CTL && !charger_write_lock) begin
      timer_ctl_next = reg_wdata;
    end
    if (reg_wr && reg_addr == CTR_OFS_THERM_CTL) begin
      therm_ctl_next = reg_wdata & CTR_THERM_CTL_WMASK;
    end
  end

  // summary status, no write path at all
  always_comb begin
    status_next = 8'h00;
    status_next[CTR_ATTACH_BIT] = attach_s;
    status_next[CTR_BATOK_BIT] = battery_valid(bat_s);
    status_next[CTR_INPWR_BIT] = (pwr_s == CTR_PWR_VALID);
    status_next[CTR_CHGOK_BIT] = !((ts_s == CTR_TS_SUSPEND_A) || (ts_s == CTR_TS_SUSPEND_B)
                                   || (tmr_s != 2'h0));
    unrel_next = ilim_s;
    fast_sec_next = fast_sec_c;
    preq_sec_next = preq_sec_c;
    topoff_next = topoff_c;
  end

  // read port, one cycle latency
  always_comb begin
    rvalid_next = reg_rd;
    rdata_next = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        CTR_OFS_TIMER_CTL: rdata_next = timer_ctl_reg;
        CTR_OFS_THERM_CTL: rdata_next = therm_ctl_reg;
        CTR_OFS_STATUS: rdata_next = status_reg;
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      timer_ctl_reg <= CTR_TIMER_CTL_RST;
      therm_ctl_reg <= CTR_THERM_CTL_RST;
      status_reg <= CTR_STATUS_RST;
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
      unrel_reg <= 1'b0;
      fast_sec_reg <= '0;
      preq_sec_reg <= '0;
      topoff_reg <= '0;
    end else begin
      timer_ctl_reg <= timer_ctl_next;
      therm_ctl_reg <= therm_ctl_next;
      status_reg <= status_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      unrel_reg <= unrel_next;
      fast_sec_reg <= fast_sec_next;
      preq_sec_reg <= preq_sec_next;
      topoff_reg <= topoff_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  assign thermistor_bias_select = timer_ctl_reg[CTR_BIAS_BIT];
  assign safety_timer_double = timer_ctl_reg[CTR_DOUBLE_BIT];
  assign fast_charge_duration = timer_ctl_reg[CTR_FAST_LSB +: 2];
  assign prequal_duration = timer_ctl_reg[CTR_PREQ_LSB +: 2];
  assign topoff_duration = timer_ctl_reg[CTR_TOPOFF_LSB +: 2];
  assign thermistor_beta_choice = therm_ctl_reg[CTR_BETA_LSB +: 3];
  assign thermal_regulation_threshold = therm_ctl_reg[CTR_THREG_LSB +: 3];
  assign fast_charge_seconds = fast_sec_reg;
  assign prequal_seconds = preq_sec_reg;
  assign topoff_deciseconds = topoff_reg;
  assign status_unreliable = unrel_reg;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  lock_blocks_write_a: assert property (
    reg_wr && reg_addr == CTR_OFS_TIMER_CTL && charger_write_lock
    |=> $stable(timer_ctl_reg)) else $error("locked write changed timer control");
  write_takes_effect_a: assert property (
    reg_wr && reg_addr == CTR_OFS_TIMER_CTL && !charger_write_lock
    |=> timer_ctl_reg == $past(reg_wdata)) else $error("timer control write lost");
  therm_write_a: assert property (
    reg_wr && reg_addr == CTR_OFS_THERM_CTL
    |=> thermistor_beta_choice == $past(reg_wdata[7:5])) else $error("beta write lost");
  status_low_zero_a: assert property (
    status_reg[3:0] == 4'h0) else $error("status reserved bits nonzero");
  therm_rsvd_zero_a: assert property (
    therm_ctl_reg[4:3] == 2'h0) else $error("thermal control reserved bits nonzero");
  power_ok_a: assert property (
    ##3 status_reg[CTR_INPWR_BIT] == ($past(input_power_detail_field, 3) == 2'h3))
    else $error("power ok mismatch");
  battery_ok_a: assert property (
    ##3 status_reg[CTR_BATOK_BIT] == ($past(battery_detail_field, 3) inside {[3'h1:3'h5], 3'h6}))
    else $error("battery ok mismatch");
  charger_ok_a: assert property (
    ##3 ($past(safety_timer_state, 3) != 2'h0) |-> !status_reg[CTR_CHGOK_BIT])
    else $error("charger ok set with timer fault");
  attach_a: assert property (
    ##3 status_reg[CTR_ATTACH_BIT] == $past(battery_attach_detected, 3))
    else $error("attach mismatch");
  doubling_a: assert property (
    timer_ctl_reg[CTR_DOUBLE_BIT]
    |=> prequal_seconds ==
        16'(16'h0002 * (16'($past(prequal_duration)) + 16'h0001) * CTR_PREQ_SEC_STEP))
    else $error("doubled prequal wrong");
  status_read_a: assert property (
    reg_rd && reg_addr == CTR_OFS_STATUS |=> reg_rvalid && reg_rdata == $past(status_reg))
    else $error("status read mismatch");

  locked_write_c: cover property (reg_wr && charger_write_lock && reg_addr == CTR_OFS_TIMER_CTL);
  status_read_c: cover property (reg_rd && reg_addr == CTR_OFS_STATUS);
  suspend_c: cover property (!status_reg[CTR_CHGOK_BIT]);
endmodule

// ===== bench/ctr_host.sv
// host model: issues single-byte register writes and reads on the byte port
// assumes the bench calls its tasks hierarchically, one at a time
`timescale 1ns/1ps
module ctr_host (
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic status_unreliable
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    int n;
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    reg_addr = ~a;
    for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) begin
      @(negedge clk);
    end
    d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    // status trusted only while no input current limit
    ok = (a != 8'h18) || (status_unreliable === 1'b0);
  endtask
endmodule

// ===== bench/charger_timer_thermal_status_regs_tb.sv
// self-checking bench for the charger control and summary status registers
// assumes ctr_regs as top, driven through the host model at falling edges
`timescale 1ns/1ps
module charger_timer_thermal_status_regs_tb;
  import ctr_pkg::*;
  logic clk, reset, reg_wr, reg_rd, reg_rvalid, charger_write_lock;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic battery_attach_detected, input_current_limit_condition, status_unreliable;
  logic [2:0] battery_detail_field, thermistor_detail_field;
  logic [1:0] input_power_detail_field, safety_timer_state;
  logic thermistor_bias_select, safety_timer_double;
  logic [1:0] fast_charge_duration, prequal_duration, topoff_duration;
  logic [2:0] thermistor_beta_choice, thermal_regulation_threshold;
  logic [15:0] fast_charge_seconds, prequal_seconds, topoff_deciseconds;
  int bad_count, checked, cyc, i;
  integer seed;
  logic [7:0] d, e16, e17, v;
  logic ok;

  ctr_regs DUT (.*);
  ctr_host u_host (.*);

  function automatic logic [47:0] dur(input logic [7:0] c);
    logic [15:0] f, p;
    f = 16'h2A30 + 16'h1C20 * 16'(c[5:4]);
    p = 16'h0384 * (16'(c[3:2]) + 16'h0001);
    if (c[6]) begin
      f = f << 1;
      p = p << 1;
    end
    return {f, p, 16'(16'h0F00 * 16'(c[1:0]))};
  endfunction
  function automatic logic [7:0] st_exp();
    return {battery_attach_detected,
      !(battery_detail_field == 3'b000 || battery_detail_field == 3'b111),
      input_power_detail_field == 2'b11,
      !(thermistor_detail_field == 3'b001 || thermistor_detail_field == 3'b100 ||
        safety_timer_state != 2'b00), 4'h0};
  endfunction
  task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check_all();
    u_host.rd(CTR_OFS_TIMER_CTL, d, ok);
    check("ctl16", 48'(d), 48'(e16));
    u_host.rd(CTR_OFS_THERM_CTL, d, ok);
    check("ctl17", 48'(d), 48'(e17));
    check("f16", 48'({thermistor_bias_select, safety_timer_double, fast_charge_duration,
      prequal_duration, topoff_duration}), 48'(e16));
    check("f17", 48'({thermistor_beta_choice, thermal_regulation_threshold}),
      48'({e17[7:5], e17[2:0]}));
    check("dur", {fast_charge_seconds, prequal_seconds, topoff_deciseconds}, dur(e16));
    u_host.rd(CTR_OFS_STATUS, d, ok);
    if (ok) check("status", 48'(d), 48'(st_exp()));
    check("unrel", 48'(status_unreliable), 48'(input_current_limit_condition));
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    seed = 32'h5d2dd159;
    reset = 1'b1;
    charger_write_lock = 1'b0;
    battery_attach_detected = 1'b0;
    battery_detail_field = 3'b111;
    input_power_detail_field = 2'b00;
    thermistor_detail_field = 3'b000;
    safety_timer_state = 2'b00;
    input_current_limit_condition = 1'b0;
    repeat (4) @(negedge clk);
    reset = 1'b0;
    e16 = 8'h95;
    e17 = 8'h24;
    check_all();
    for (i = 0; i < 24; i++) begin
      battery_attach_detected = 1'($random(seed));
      battery_detail_field = i[2:0];
      input_power_detail_field = 2'($random(seed));
      thermistor_detail_field = 3'($random(seed));
      safety_timer_state = (i % 4 == 0) ? 2'($random(seed)) : 2'b00;
      input_current_limit_condition = (i % 5 == 4);
      charger_write_lock = (i < 2) || (i % 3 == 0);
      v = (i == 2) ? 8'h00 : ((i == 3) ? 8'hFF : 8'($random(seed)));
      u_host.wr(CTR_OFS_TIMER_CTL, v);
      if (!charger_write_lock) e16 = v;
      v = 8'($random(seed));
      u_host.wr(CTR_OFS_THERM_CTL, v);
      e17 = v & 8'hE7;
      u_host.wr(CTR_OFS_STATUS, 8'($random(seed)));
      check_all();
      v = 8'($random(seed));
      if (v >= 8'h16 && v <= 8'h18) v = v + 8'h03;
      u_host.rd(v, d, ok);
      check("unmapped", 48'(d), 48'h0);
    end
    close_out();
  end
endmodule
